// ### shared/swt_pkg.sv
// Register map, field layout and step patterns of the stopwatch timer
`default_nettype none

package swt_pkg;

  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned DIG_W  = 4;

  // Register indices; the byte address is four times the index
  localparam logic [15:0] IDX_CTRL  = 16'hff7c;
  localparam logic [15:0] IDX_HUND  = 16'hff7d;
  localparam logic [15:0] IDX_TENTH = 16'hff7e;
  localparam logic [15:0] IDX_MASK  = 16'hffe7;
  localparam logic [15:0] IDX_FLAGS = 16'hfff7;

  localparam logic [ADDR_W-1:0] ADDR_CTRL  = {IDX_CTRL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_HUND  = {IDX_HUND, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_TENTH = {IDX_TENTH, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_MASK  = {IDX_MASK, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = {IDX_FLAGS, 2'h0};

  // Field positions
  localparam int unsigned BIT_RUN    = 0;
  localparam int unsigned BIT_CLEAR  = 1;
  localparam int unsigned BIT_TENTH  = 0;
  localparam int unsigned BIT_SECOND = 1;

  // Reset values
  localparam logic [DIG_W-1:0] RST_DIGIT = 4'h0;
  localparam logic             RST_RUN   = 1'h0;
  localparam logic [1:0]       RST_MASK  = 2'h0;
  localparam logic [1:0]       RST_FLAGS = 2'h0;

  localparam logic [DIG_W-1:0] DIGIT_MAX = 4'h9;

  // Bit i set: step leaving digit value i waits three ticks, else two
  localparam logic [9:0] PAT_SHORT = 10'h2aa;
  localparam logic [9:0] PAT_LONG  = 10'h1ad;
  // Bit i set: tenth number i lasts 26 ticks, else 25
  localparam logic [9:0] PAT_TENTH = 10'h1ad;

  localparam logic [1:0] TICKS_SHORT = 2'h2;
  localparam logic [1:0] TICKS_LONG  = 2'h3;
  localparam logic [4:0] CYC_SHORT   = 5'h19;
  localparam logic [4:0] CYC_LONG    = 5'h1a;
  localparam logic [8:0] SEC_TICKS   = 9'h100;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [3:0]        byteenable;
    logic [DATA_W-1:0] writedata;
  } swt_avs_req_t;

  typedef struct packed {
    logic second;
    logic tenth;
  } swt_irq_t;

endpackage : swt_pkg

`default_nettype wire

// ### rtl/swt_stopwatch.sv
// Two-digit BCD stopwatch timer with Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none

module swt_stopwatch (
  input  wire logic                        ref_clk_i,
  input  wire logic                        nrst_i,
  input  wire logic                        tick_256_i,
  input  wire swt_pkg::swt_avs_req_t       avs_req_i,
  output logic [swt_pkg::DATA_W-1:0]       avs_readdata_o,
  output logic                             avs_waitrequest_o,
  output swt_pkg::swt_irq_t                irq_o
);
  import swt_pkg::*;

  logic [DIG_W-1:0]  hund_q;
  logic [DIG_W-1:0]  tenth_q;
  logic [1:0]        tick_cnt_q;
  logic              run_q;
  logic [1:0]        mask_q;
  logic [1:0]        flags_q;
  logic              ack_q;
  logic [DATA_W-1:0] rdata_q;
  swt_irq_t          irq_q;

  logic              req;
  logic              wr_acc;
  logic              wr_lane;
  logic              wr_ctrl;
  logic              wr_mask;
  logic              wr_flags;
  logic              clear_wr;
  logic              long_tenth;
  logic              three_ticks;
  logic [1:0]        interval;
  logic              run_tick;
  logic              step;
  logic              hund_wrap;
  logic              tenth_wrap;
  logic [1:0]        flags_set;
  logic [1:0]        flags_clr;
  logic [DATA_W-1:0] rdata_d;

  // Bus slave: one wait cycle, then accept
  assign req               = avs_req_i.read | avs_req_i.write;
  assign avs_waitrequest_o = req & ~ack_q;
  assign wr_acc            = avs_req_i.write & ack_q;
  assign wr_lane           = wr_acc & avs_req_i.byteenable[0];
  assign wr_ctrl           = wr_lane & (avs_req_i.address == ADDR_CTRL);
  assign wr_mask           = wr_lane & (avs_req_i.address == ADDR_MASK);
  assign wr_flags          = wr_lane & (avs_req_i.address == ADDR_FLAGS);
  assign clear_wr          = wr_ctrl & avs_req_i.writedata[BIT_CLEAR];

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Step pattern: interval chosen by tenth length and hundredths value
  assign long_tenth  = PAT_TENTH[tenth_q];
  assign three_ticks = long_tenth ? PAT_LONG[hund_q]
                                  : PAT_SHORT[hund_q];
  assign interval    = three_ticks ? TICKS_LONG : TICKS_SHORT;
  assign run_tick    = tick_256_i & run_q;
  assign step        = run_tick & (tick_cnt_q == interval - 2'h1);
  assign hund_wrap   = step & (hund_q == DIGIT_MAX);
  assign tenth_wrap  = hund_wrap & (tenth_q == DIGIT_MAX);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_cnt_q <= 2'h0;
    end else if (clear_wr || step) begin
      tick_cnt_q <= 2'h0;
    end else if (run_tick) begin
      tick_cnt_q <= tick_cnt_q + 2'h1;
    end
  end

  // Clear overrides a step in the same cycle; the same CTRL write also loads run from bit 0
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hund_q <= RST_DIGIT;
    end else if (clear_wr) begin
      hund_q <= RST_DIGIT;
    end else if (step) begin
      hund_q <= hund_wrap ? RST_DIGIT : hund_q + 4'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tenth_q <= RST_DIGIT;
    end else if (clear_wr) begin
      tenth_q <= RST_DIGIT;
    end else if (hund_wrap) begin
      tenth_q <= tenth_wrap ? RST_DIGIT : tenth_q + 4'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_q <= RST_RUN;
    end else if (wr_ctrl) begin
      run_q <= avs_req_i.writedata[BIT_RUN];
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_q <= RST_MASK;
    end else if (wr_mask) begin
      mask_q <= avs_req_i.writedata[1:0];
    end
  end

  // Set beats write-one-clear so an event in the clear cycle survives
  assign flags_set[BIT_TENTH]  = hund_wrap;
  assign flags_set[BIT_SECOND] = tenth_wrap;
  assign flags_clr = wr_flags ? avs_req_i.writedata[1:0] : 2'h0;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_q <= RST_FLAGS;
    end else begin
      flags_q <= (flags_q & ~flags_clr) | flags_set;
    end
  end

  // Request is a level: stays up until flag cleared or masked
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_q <= '0;
    end else begin
      irq_q.tenth  <= flags_q[BIT_TENTH] & mask_q[BIT_TENTH];
      irq_q.second <= flags_q[BIT_SECOND] & mask_q[BIT_SECOND];
    end
  end
  assign irq_o = irq_q;

  // Read data captured in the wait cycle; unmapped reads give zero
  always_comb begin
    rdata_d = '0;
    case (avs_req_i.address)
      ADDR_CTRL:  rdata_d[BIT_RUN] = run_q;
      ADDR_HUND:  rdata_d[DIG_W-1:0] = hund_q;
      ADDR_TENTH: rdata_d[DIG_W-1:0] = tenth_q;
      ADDR_MASK:  rdata_d[1:0] = mask_q;
      ADDR_FLAGS: rdata_d[1:0] = flags_q;
      default:    rdata_d = '0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= '0;
    end else if (avs_req_i.read && !ack_q) begin
      rdata_q <= rdata_d;
    end
  end
  assign avs_readdata_o = rdata_q;

  // Helper counters seen only by the checks below
  logic [1:0] chk_gap_q;
  logic [4:0] chk_cyc_q;
  logic [8:0] chk_sec_q;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chk_gap_q <= 2'h0;
      chk_cyc_q <= 5'h0;
      chk_sec_q <= 9'h0;
    end else begin
      if (clear_wr || step) begin
        chk_gap_q <= 2'h0;
      end else if (run_tick && chk_gap_q != 2'h3) begin
        chk_gap_q <= chk_gap_q + 2'h1;
      end
      if (clear_wr || hund_wrap) begin
        chk_cyc_q <= 5'h0;
      end else if (run_tick) begin
        chk_cyc_q <= chk_cyc_q + 5'h1;
      end
      if (clear_wr || tenth_wrap) begin
        chk_sec_q <= 9'h0;
      end else if (run_tick) begin
        chk_sec_q <= chk_sec_q + 9'h1;
      end
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_wrap_no_clear;
    hund_wrap && !clear_wr;
  endsequence

  sequence s_ctrl_read;
    avs_req_i.read && !ack_q && avs_req_i.address == ADDR_CTRL;
  endsequence

  AST_DIGITS_BCD: assert property (
    hund_q <= DIGIT_MAX && tenth_q <= DIGIT_MAX)
    else $error("Digit left the BCD range");

  AST_TENTH_ADVANCE: assert property (
    s_wrap_no_clear |=> tenth_q == ($past(tenth_q) == DIGIT_MAX ?
                                    RST_DIGIT : $past(tenth_q) + 4'h1))
    else $error("Tenths digit did not follow the carry");

  AST_STEP_GAP: assert property (
    step && !clear_wr |-> (chk_gap_q == 2'h1 || chk_gap_q == 2'h2))
    else $error("Hundredths step not two or three ticks apart");

  AST_CYCLE_LEN: assert property (
    hund_wrap |-> (chk_cyc_q + 5'h1 == CYC_SHORT ||
                   chk_cyc_q + 5'h1 == CYC_LONG))
    else $error("Tenth cycle not 25 or 26 ticks");

  AST_SECOND_LEN: assert property (
    tenth_wrap |-> {1'b0, chk_sec_q} + 10'h1 == {1'b0, SEC_TICKS})
    else $error("Second not 256 ticks");

  AST_FLAG_SET: assert property (
    tenth_wrap |=> flags_q[BIT_SECOND] && flags_q[BIT_TENTH])
    else $error("Wrap did not set the flags");

  AST_W1C: assert property (
    wr_flags && avs_req_i.writedata[BIT_TENTH] && !hund_wrap
    |=> !flags_q[BIT_TENTH])
    else $error("Write one did not clear the flag");

  AST_IRQ_HOLD: assert property (
    flags_q[BIT_TENTH] && mask_q[BIT_TENTH] ##1
    flags_q[BIT_TENTH] && mask_q[BIT_TENTH] |-> irq_o.tenth)
    else $error("Request dropped while flag and mask set");

  AST_CLEAR_ZERO: assert property (
    clear_wr |=> hund_q == RST_DIGIT && tenth_q == RST_DIGIT)
    else $error("Clear did not zero the digits");

  AST_CLEAR_READS_ZERO: assert property (
    s_ctrl_read |=> !avs_readdata_o[BIT_CLEAR])
    else $error("Clear bit read back as one");

  AST_STOP_HOLD: assert property (
    !run_q && !clear_wr |=> $stable(hund_q) && $stable(tenth_q))
    else $error("Digits moved while stopped");

  AST_BUS_ANSWER: assert property (
    req && !ack_q |=> !avs_waitrequest_o)
    else $error("Slave did not answer in one wait cycle");

  // Read captures happen in the wait cycle, so look one edge later
  sequence s_hund_read;
    avs_req_i.read && !ack_q && avs_req_i.address == ADDR_HUND;
  endsequence

  sequence s_tenth_read;
    avs_req_i.read && !ack_q && avs_req_i.address == ADDR_TENTH;
  endsequence

  sequence s_flags_read;
    avs_req_i.read && !ack_q && avs_req_i.address == ADDR_FLAGS;
  endsequence

  sequence s_digit_write;
    wr_acc && !step && (avs_req_i.address == ADDR_HUND ||
                        avs_req_i.address == ADDR_TENTH);
  endsequence

  AST_HUND_STEP: assert property (
    step && !clear_wr |=> hund_q == ($past(hund_q) == DIGIT_MAX ?
                                     RST_DIGIT : $past(hund_q) + 4'h1))
    else $error("Hundredths digit did not step by one");

  AST_TENTH_HOLD: assert property (
    !hund_wrap && !clear_wr |=> $stable(tenth_q))
    else $error("Tenths digit moved without a carry");

  AST_TICK_BOUND: assert property (
    tick_cnt_q < TICKS_LONG)
    else $error("Tick counter passed the longest interval");

  AST_STEP_PATTERN: assert property (
    step && !clear_wr |-> chk_gap_q + 2'h1 ==
      ((PAT_TENTH[tenth_q] ? PAT_LONG[hund_q] : PAT_SHORT[hund_q]) ?
       TICKS_LONG : TICKS_SHORT))
    else $error("Hundredths step off its fixed pattern");

  AST_TENTH_PATTERN: assert property (
    hund_wrap |-> chk_cyc_q + 5'h1 ==
      (PAT_TENTH[tenth_q] ? CYC_LONG : CYC_SHORT))
    else $error("Tenth length off its fixed pattern");

  AST_TENTH_FLAG: assert property (
    hund_wrap |=> flags_q[BIT_TENTH])
    else $error("Hundredths wrap did not set its flag");

  AST_FLAG_UNMASKED: assert property (
    hund_wrap && !mask_q[BIT_TENTH] |=> flags_q[BIT_TENTH])
    else $error("Masked event did not set its flag");

  AST_FLAG_WRITE_ZERO: assert property (
    wr_flags && !avs_req_i.writedata[BIT_SECOND] && flags_q[BIT_SECOND]
    |=> flags_q[BIT_SECOND])
    else $error("Writing zero cleared a flag");

  AST_FLAG_READ: assert property (
    s_flags_read |=> avs_readdata_o[1:0] == $past(flags_q) &&
                     avs_readdata_o[DATA_W-1:2] == '0)
    else $error("Flag read returned the wrong value");

  AST_MASK_WRITE: assert property (
    wr_mask |=> mask_q == $past(avs_req_i.writedata[1:0]))
    else $error("Mask write not taken");

  AST_IRQ_MASKED: assert property (
    !mask_q[BIT_SECOND] |=> !irq_o.second)
    else $error("Masked request reached the output");

  AST_IRQ_SECOND: assert property (
    flags_q[BIT_SECOND] && mask_q[BIT_SECOND] |=> irq_o.second)
    else $error("Second request not raised");

  AST_RUN_WRITE: assert property (
    wr_ctrl |=> run_q == $past(avs_req_i.writedata[BIT_RUN]))
    else $error("Run bit write not taken");

  AST_CLEAR_RESTART: assert property (
    clear_wr |=> tick_cnt_q == 2'h0)
    else $error("Clear left a partial interval behind");

  AST_STOP_NO_STEP: assert property (
    !run_q |-> !step)
    else $error("Hundredths stepped while stopped");

  AST_DIGIT_WRITE_IGNORED: assert property (
    s_digit_write |=> $stable(hund_q) && $stable(tenth_q))
    else $error("Write to a digit register changed it");

  AST_HUND_READ: assert property (
    s_hund_read |=> avs_readdata_o[DIG_W-1:0] == $past(hund_q) &&
                    avs_readdata_o[DATA_W-1:DIG_W] == '0)
    else $error("Hundredths read returned the wrong value");

  AST_TENTH_READ: assert property (
    s_tenth_read |=> avs_readdata_o[DIG_W-1:0] == $past(tenth_q) &&
                     avs_readdata_o[DATA_W-1:DIG_W] == '0)
    else $error("Tenths read returned the wrong value");

  AST_IDLE_NO_WAIT: assert property (
    !req |-> !avs_waitrequest_o)
    else $error("Waitrequest raised with no request");

endmodule : swt_stopwatch

`default_nettype wire

// ### testbench/swt_stopwatch_bench.sv
// Self-checking bench for the stopwatch timer
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  n_errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end

module swt_stopwatch_bench;
  import swt_pkg::*;
  logic              ref_clk_i   = 1'b0;
  logic              nrst_i      = 1'b0;
  logic              tick_256_i  = 1'b0;
  swt_avs_req_t      req         = '0;
  logic [DATA_W-1:0] rdata;
  logic              wreq;
  swt_irq_t          irq;
  int                n_errors    = 0;
  int                check_count = 0;
  logic [DATA_W-1:0] rd;
  int                iv;
  int                total;

  swt_stopwatch dut_u (
    .ref_clk_i         (ref_clk_i),
    .nrst_i            (nrst_i),
    .tick_256_i        (tick_256_i),
    .avs_req_i         (req),
    .avs_readdata_o    (rdata),
    .avs_waitrequest_o (wreq),
    .irq_o             (irq)
  );

  always #2 ref_clk_i = ~ref_clk_i;

  // Waitrequest read right at the edge, before that edge updates it
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [3:0] be);
    logic w;
    int   n;
    n = 0;
    @(posedge ref_clk_i);
    req.read <= ~wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= d;
    req.byteenable <= be;
    do begin
      @(posedge ref_clk_i);
      w = wreq;
      n++;
    end while (w !== 1'b0 && n < 20);
    `CHK(w, 1'b0)
    rd = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rd_chk(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] e);
    bus(1'b0, a, '0, 4'hf);
    `CHK(rd, e)
  endtask : rd_chk

  // Two clocks per tick; trailing edges let the step and flags land
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      tick_256_i <= 1'b1;
      @(posedge ref_clk_i);
      tick_256_i <= 1'b0;
    end
    repeat (2) @(posedge ref_clk_i);
  endtask : tick

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (40000) @(posedge ref_clk_i);
    n_errors++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd_chk(ADDR_CTRL, 32'h0);
    rd_chk(ADDR_HUND, 32'h0);
    rd_chk(ADDR_TENTH, 32'h0);
    rd_chk(ADDR_MASK, 32'h0);
    rd_chk(ADDR_FLAGS, 32'h0);
    rd_chk(18'h00010, 32'h0);
    wr(ADDR_HUND, 32'h5);
    wr(ADDR_TENTH, 32'h7);
    wr(18'h00010, 32'hf);
    rd_chk(ADDR_HUND, 32'h0);
    rd_chk(ADDR_TENTH, 32'h0);
    wr(ADDR_MASK, 32'h1);
    bus(1'b1, ADDR_MASK, 32'h0, 4'h0);
    rd_chk(ADDR_MASK, 32'h1);
    $display("test reset and access done");
    wr(ADDR_CTRL, 32'h1);
    rd_chk(ADDR_CTRL, 32'h1);
    total = 0;
    for (int t = 0; t < 10; t++) begin
      for (int h = 0; h < 10; h++) begin
        iv = (PAT_TENTH[t] ? PAT_LONG[h] : PAT_SHORT[h]) ? 3 : 2;
        tick(iv - 1);
        rd_chk(ADDR_HUND, 32'(h));
        tick(1);
        total += iv;
        rd_chk(ADDR_HUND, 32'((h + 1) % 10));
      end
      rd_chk(ADDR_TENTH, 32'((t + 1) % 10));
      rd_chk(ADDR_FLAGS, (t == 9) ? 32'h3 : 32'h1);
      if (t == 0) begin
        wr(ADDR_FLAGS, 32'h0);
        rd_chk(ADDR_FLAGS, 32'h1);
        `CHK(irq.tenth, 1'b1)
      end
      if (t == 9) begin
        `CHK(irq.second, 1'b0)
        wr(ADDR_MASK, 32'h3);
        rd_chk(ADDR_MASK, 32'h3);
        `CHK(irq.second, 1'b1)
      end
      wr(ADDR_FLAGS, 32'h3);
      rd_chk(ADDR_FLAGS, 32'h0);
      `CHK(irq, 2'h0)
    end
    `CHK(total, 256)
    $display("test full second done");
    tick(3);
    rd_chk(ADDR_HUND, 32'h1);
    wr(ADDR_CTRL, 32'h0);
    rd_chk(ADDR_CTRL, 32'h0);
    tick(6);
    rd_chk(ADDR_HUND, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    tick(2);
    rd_chk(ADDR_HUND, 32'h2);
    wr(ADDR_CTRL, 32'h0);
    rd_chk(ADDR_HUND, 32'h2);
    rd_chk(ADDR_TENTH, 32'h0);
    wr(ADDR_CTRL, 32'h1);
    $display("test stop and resume done");
    wr(ADDR_CTRL, 32'h3);
    rd_chk(ADDR_HUND, 32'h0);
    rd_chk(ADDR_CTRL, 32'h1);
    tick(3);
    rd_chk(ADDR_HUND, 32'h1);
    wr(ADDR_CTRL, 32'h2);
    rd_chk(ADDR_HUND, 32'h0);
    tick(4);
    rd_chk(ADDR_HUND, 32'h0);
    wr(ADDR_CTRL, 32'h1);
    tick(3);
    rd_chk(ADDR_HUND, 32'h1);
    $display("test clear done");
    report_and_stop();
  end
endmodule : swt_stopwatch_bench
`default_nettype wire
